/* File: bench/mgmt_packet_steering_ctrl_tb_top.sv */
// Self-checking testbench for the packet steering control block.
`timescale 1ns/1ps
`default_nettype none
module mgmt_packet_steering_ctrl_tb_top;
    import mpsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, ctrl_m, d, q;
    logic nvm_phy_reset_inhibit, remote_reset_req, pcie_reset_pin_n, inband_pcie_reset;
    logic lowpower_req, pkt_valid, wake_arp_in, mgmt_forward, wake_arp_hit;
    logic phy_reset, phy_power_keep, phy_powerdown, run, filters_off, chk_en, er;
    logic [7:0] pkt_attr, decision_filter_hit, host_copy, mask_m;
    logic [9:0] e_q;
    wire pkt_l2_pass, pkt_multicast, pkt_broadcast, pkt_xsum_ok;
    wire pkt_vlan_tagged, pkt_arp_request, pkt_ip_filter_valid, pkt_ip_match;
    integer seed = 2;
    int n_fail = 0;
    int n_tests = 0;
    assign {pkt_l2_pass, pkt_multicast, pkt_broadcast, pkt_xsum_ok, pkt_vlan_tagged,
        pkt_arp_request, pkt_ip_filter_valid, pkt_ip_match} = pkt_attr;

    mpsc_top DUT (.*);
    mpsc_pkt_model partner (.*);

    // ------------------------------------------------------------
    // Expectation functions
    // ------------------------------------------------------------
    function automatic logic [31:0] ctrl_after(input logic [31:0] o, input logic [31:0] v,
        input logic s);
        logic [31:0] wm;
        wm = '0;
        wm[B_RX_EN] = 1'b1;
        wm[B_MGMT_RECEIVE_EVERYTHING] = 1'b1;
        wm[B_MCAST] = 1'b1;
        wm[B_HOST_EN] = 1'b1;
        wm[B_XSUM] = 1'b1;
        wm[B_TYPE_LOCK] = 1'b1;
        wm[B_TYPE_SEL] = 1'b1;
        wm[B_ARP_DIS] = 1'b1;
        wm[B_HOLD] = s;
        return (o & ~wm) | (v & wm);
    endfunction

    function automatic logic [9:0] expect_pkt(input logic [31:0] c, input logic [7:0] m,
        input logic [17:0] p);
        logic g;
        g = p[17] & c[B_RX_EN] & (p[16] | (c[B_MCAST] & p[15] & !p[14]))
            & (!c[B_XSUM] | p[13]) & (!c[B_TYPE_LOCK] | (p[12] == c[B_TYPE_SEL]))
            & (!p[11] | c[B_ARP_DIS] | (p[10] & p[9]));
        return {g & (c[B_MGMT_RECEIVE_EVERYTHING] | (|p[8:1])),
            g ? (p[8:1] & m & {8{c[B_HOST_EN]}}) : 8'h00,
            p[17] & p[11] & p[0]};
    endfunction

    // ------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
        if (a == ADDR_CTRL) ctrl_m = ctrl_after(ctrl_m, v, nvm_phy_reset_inhibit);
        if (a == ADDR_HOST) mask_m = v[7:0];
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, q, e);
    endtask

    task automatic wrap_up;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(negedge pclk) begin
        if (chk_en) begin
            chk("packet", {22'h0, mgmt_forward, host_copy, wake_arp_hit}, {22'h0, e_q});
            e_q = expect_pkt(ctrl_m, mask_m, {pkt_valid, pkt_attr, decision_filter_hit,
                wake_arp_in});
        end
    end

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, run, filters_off, chk_en} = '0;
        {nvm_phy_reset_inhibit, remote_reset_req, inband_pcie_reset, lowpower_req} = '0;
        {presetn, e_q, mask_m} = '0;
        pcie_reset_pin_n = 1'b1;
        ctrl_m = 32'h1000_0000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'h1000_0000, "ctrl reset");
        rd(ADDR_HOST, 32'h0000_0000, "mask reset");
        wr(ADDR_CTRL, 32'hffff_ffff);
        rd(ADDR_CTRL, ctrl_m, "ctrl ones");
        chk("keep", phy_power_keep, 1'b1);
        wr(ADDR_HOST, 32'hffff_ffff);
        rd(ADDR_HOST, 32'h0000_00ff, "mask ones");
        apb(1'b1, 16'h5864, 32'hffff_ffff);
        chk("unmapped err", er, 1'b1);
        rd(16'h5864, 32'h0000_0000, "unmapped rd");
        $display("register test done");
        nvm_phy_reset_inhibit <= 1'b1;
        repeat (3) @(posedge pclk);
        wr(ADDR_CTRL, 32'h1004_0000);
        rd(ADDR_CTRL, ctrl_m, "hold set");
        pcie_reset_pin_n <= 1'b0;
        inband_pcie_reset <= 1'b1;
        lowpower_req <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("reset blocked", phy_reset, 1'b0);
        chk("power frozen", {phy_power_keep, phy_powerdown}, 2'b10);
        remote_reset_req <= 1'b1;
        repeat (5) @(posedge pclk);
        ctrl_m[B_REMOTE] = 1'b1;
        rd(ADDR_CTRL, ctrl_m, "remote flag");
        wr(ADDR_CTRL, 32'h1000_0000);
        repeat (3) @(posedge pclk);
        chk("phy state", {phy_reset, phy_power_keep, phy_powerdown}, 3'b101);
        {pcie_reset_pin_n, inband_pcie_reset, lowpower_req, nvm_phy_reset_inhibit} <= 4'b1000;
        remote_reset_req <= 1'b0;
        repeat (3) @(posedge pclk);
        wr(ADDR_CTRL, 32'h1004_0000);
        rd(ADDR_CTRL, ctrl_m, "hold locked");
        $display("phy test done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            if (i < 6) d[B_RX_EN] = 1'b1;
            if (i == 0) d = 32'h0002_0000;
            if (i == 1) d = 32'hffff_ffff;
            wr(ADDR_CTRL, d);
            wr(ADDR_HOST, $random(seed));
            filters_off <= ctrl_m[B_MGMT_RECEIVE_EVERYTHING];
            run <= 1'b1;
            chk_en = 1'b1;
            repeat (60) @(posedge pclk);
            run <= 1'b0;
            repeat (2) @(posedge pclk);
            chk_en = 1'b0;
        end
        $display("packet test done");
        nvm_phy_reset_inhibit <= 1'b1;
        repeat (3) @(posedge pclk);
        wr(ADDR_CTRL, 32'h1004_0000);
        rd(ADDR_CTRL, ctrl_m, "hold before reset");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CTRL, 32'h1000_0000, "power on");
        rd(ADDR_HOST, 32'h0000_0000, "mask power on");
        $display("second reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: bench/mpsc_pkt_model.sv */
// Receive filter datapath model offering random packet attributes.
`timescale 1ns/1ps
`default_nettype none
module mpsc_pkt_model (
    input wire logic pclk,
    input wire logic run,
    input wire logic filters_off,
    output logic pkt_valid,
    output logic [7:0] pkt_attr,
    output logic [mpsc_pkg::NUM_FILT-1:0] decision_filter_hit,
    output logic wake_arp_in
);
    integer seed = 2;
    logic [31:0] r;
    // Attributes change every cycle, so idle cycles never show stale values.
    always @(posedge pclk) begin
        r = $random(seed);
        pkt_valid <= run & r[0];
        pkt_attr <= r[8:1];
        wake_arp_in <= r[9];
        decision_filter_hit <= filters_off ? 8'h00 : r[17:10];
    end
endmodule
`default_nettype wire

/* File: core/mpsc_cfg_if.sv */
// Configuration carried from the register file to the steering logic.
`timescale 1ns/1ps
`default_nettype none
interface mpsc_cfg_if;
    logic rx_en;
    logic mgmt_receive_everything;
    logic mcast_pass;
    logic host_en;
    logic xsum_gate;
    logic type_lock;
    logic type_sel;
    logic arp_dis;
    logic hold;
    logic [mpsc_pkg::NUM_FILT-1:0] host_mask;
    modport src(output rx_en, mgmt_receive_everything, mcast_pass, host_en, xsum_gate, type_lock,
        type_sel, arp_dis, hold, host_mask);
    modport steer(input rx_en, mgmt_receive_everything, mcast_pass, host_en, xsum_gate, type_lock,
        type_sel, arp_dis, host_mask);
    modport phy(input rx_en, hold);
endinterface
`default_nettype wire

/* File: core/mpsc_phy_guard.sv */
// PHY reset and power hold logic.
`timescale 1ns/1ps
`default_nettype none
module mpsc_phy_guard (
    input wire logic pclk,
    input wire logic presetn,
    mpsc_cfg_if.phy cfg,
    input wire logic pcie_reset,
    input wire logic lowpower_req,
    output logic phy_reset,
    output logic phy_power_keep,
    output logic phy_powerdown
);
    logic next_reset;
    logic next_keep;
    logic next_down;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_reset = pcie_reset & ~cfg.hold;
        next_keep = cfg.hold | cfg.rx_en;
        // While held, the power state is frozen where it stands.
        next_down = cfg.hold ? phy_powerdown : (lowpower_req & ~cfg.rx_en);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_reset <= 1'b0;
            phy_power_keep <= 1'b0;
            phy_powerdown <= 1'b0;
        end else begin
            phy_reset <= next_reset;
            phy_power_keep <= next_keep;
            phy_powerdown <= next_down;
        end
    end
endmodule
`default_nettype wire

/* File: core/mpsc_pkg.sv */
// Constants shared by the packet steering control block.
`default_nettype none
package mpsc_pkg;
    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int NUM_FILT = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 16'h5820;
    localparam logic [ADDR_W-1:0] ADDR_HOST = 16'h5860;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int B_REMOTE = 16;
    localparam int B_RX_EN = 17;
    localparam int B_HOLD = 18;
    localparam int B_MGMT_RECEIVE_EVERYTHING = 19;
    localparam int B_MCAST = 20;
    localparam int B_HOST_EN = 21;
    localparam int B_XSUM = 23;
    localparam int B_TYPE_LOCK = 25;
    localparam int B_TYPE_SEL = 26;
    localparam int B_ARP_DIS = 28;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h1000_0000;
    // Plain writable fields; the hold and remote bits are handled apart.
    localparam logic [DATA_W-1:0] CTRL_WR_MASK = 32'h16ba_0000;
    localparam logic [DATA_W-1:0] CTRL_RD_MASK = 32'h16bf_0000;
    localparam logic [NUM_FILT-1:0] HOST_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: core/mpsc_steer.sv */
// Per-packet manageability and host-copy decision.
`timescale 1ns/1ps
`default_nettype none
module mpsc_steer (
    input wire logic pclk,
    input wire logic presetn,
    mpsc_cfg_if.steer cfg,
    input wire logic pkt_valid,
    input wire logic pkt_l2_pass,
    input wire logic pkt_multicast,
    input wire logic pkt_broadcast,
    input wire logic pkt_xsum_ok,
    input wire logic pkt_vlan_tagged,
    input wire logic pkt_arp_request,
    input wire logic pkt_ip_filter_valid,
    input wire logic pkt_ip_match,
    input wire logic [mpsc_pkg::NUM_FILT-1:0] decision_filter_hit,
    input wire logic wake_arp_in,
    output logic mgmt_forward,
    output logic [mpsc_pkg::NUM_FILT-1:0] host_copy,
    output logic wake_arp_hit
);
    import mpsc_pkg::*;

    logic l2_ok;
    logic gate_ok;
    logic routed;
    logic next_fwd;
    logic next_wake;
    logic [NUM_FILT-1:0] next_copy;

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    always_comb begin
        // Multicast pass never admits broadcast frames.
        l2_ok = pkt_l2_pass | (cfg.mcast_pass & pkt_multicast & ~pkt_broadcast);
        gate_ok = cfg.rx_en & l2_ok;
        gate_ok = gate_ok & (~cfg.xsum_gate | pkt_xsum_ok);
        gate_ok = gate_ok & (~cfg.type_lock | (pkt_vlan_tagged == cfg.type_sel));
        gate_ok = gate_ok & (~pkt_arp_request | cfg.arp_dis
            | (pkt_ip_filter_valid & pkt_ip_match));
        routed = cfg.mgmt_receive_everything | (|decision_filter_hit);
        next_fwd = pkt_valid & gate_ok & routed;
        // Wake-up ARP matching ignores the manageability ARP setting.
        next_wake = pkt_valid & pkt_arp_request & wake_arp_in;
    end

    for (genvar n = 0; n < NUM_FILT; n++) begin : g_copy
        assign next_copy[n] = pkt_valid & gate_ok & decision_filter_hit[n]
            & cfg.host_mask[n] & cfg.host_en;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_forward <= 1'b0;
            host_copy <= HOST_RESET;
            wake_arp_hit <= 1'b0;
        end else begin
            mgmt_forward <= next_fwd;
            host_copy <= next_copy;
            wake_arp_hit <= next_wake;
        end
    end
endmodule
`default_nettype wire

/* File: core/mpsc_top.sv */
// Management packet steering control: registers, APB slave and wiring.
//
// What this block does
// - Remote management reset sets a sticky flag at bit 16; only power-on clears it.
// - Bit 17 enables forwarding received packets into the manageability block.
// - Bit 18 blocks PHY reset from PCIe resets and freezes PHY power state.
// - Writes to bit 18 are ignored unless the NVM reset-inhibit strap is set.
// - Power-on reset, or a write of 0 while the strap is set, clears bit 18.
// - Bit 19 sends every L2-passed packet to manageability.
// - Bit 20 passes all multicast through L2 filtering, never broadcast.
// - Bit 21 globally gates host copy; clear means no host copies.
// - Bit 23 admits only packets with good L3 and L4 checksums.
// - Bit 25 locks manageability traffic to one tag type.
// - Bit 26 picks untagged when 0, tagged when 1, only while locked.
// - Bit 28 resets to 1 and skips ARP IP matching while set.
// - The ARP setting never alters wake-up ARP matching.
// - Bit 17 keeps the PHY powered in power-saving states.
// - Filter n routed packets also go to host if mask bit n and enable set.
// - Power-on reset clears the host copy mask.
// - Eight decision filters 0 to 7 map onto mask bits 7:0.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mpsc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mpsc_pkg::ADDR_W-1:0] paddr,
    input wire logic [mpsc_pkg::DATA_W-1:0] pwdata,
    output logic [mpsc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nvm_phy_reset_inhibit,
    input wire logic remote_reset_req,
    input wire logic pcie_reset_pin_n,
    input wire logic inband_pcie_reset,
    input wire logic lowpower_req,
    input wire logic pkt_valid,
    input wire logic pkt_l2_pass,
    input wire logic pkt_multicast,
    input wire logic pkt_broadcast,
    input wire logic pkt_xsum_ok,
    input wire logic pkt_vlan_tagged,
    input wire logic pkt_arp_request,
    input wire logic pkt_ip_filter_valid,
    input wire logic pkt_ip_match,
    input wire logic [mpsc_pkg::NUM_FILT-1:0] decision_filter_hit,
    input wire logic wake_arp_in,
    output logic mgmt_forward,
    output logic [mpsc_pkg::NUM_FILT-1:0] host_copy,
    output logic wake_arp_hit,
    output logic phy_reset,
    output logic phy_power_keep,
    output logic phy_powerdown
);
    import mpsc_pkg::*;

    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] next_ctrl;
    logic [NUM_FILT-1:0] host_mask;
    logic [NUM_FILT-1:0] next_host_mask;
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic hit_ctrl;
    logic hit_host;
    logic wr_ctrl;
    logic wr_host;
    logic strap_m;
    logic strap_s;
    logic rrst_m;
    logic rrst_s;
    logic rrst_d;
    logic rrst_pulse;
    logic pin_m;
    logic pin_s_n;
    logic pcie_reset;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_m <= 1'b0;
            strap_s <= 1'b0;
            rrst_m <= 1'b0;
            rrst_s <= 1'b0;
            rrst_d <= 1'b0;
            pin_m <= 1'b1;
            pin_s_n <= 1'b1;
        end else begin
            strap_m <= nvm_phy_reset_inhibit;
            strap_s <= strap_m;
            rrst_m <= remote_reset_req;
            rrst_s <= rrst_m;
            rrst_d <= rrst_s;
            pin_m <= pcie_reset_pin_n;
            pin_s_n <= pin_m;
        end
    end

    // The remote reset request is a level; only its rising edge counts as an event.
    assign rrst_pulse = rrst_s & ~rrst_d;
    // Either the synchronised pin or the in-band request asks for a PHY reset.
    assign pcie_reset = ~pin_s_n | inband_pcie_reset;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // The access phase lasts two cycles: pready rises one edge after penable.
    assign hit_ctrl = (paddr == ADDR_CTRL);
    assign hit_host = (paddr == ADDR_HOST);
    // Any other address is answered with pslverr and reads as zero.
    // Writes land at the edge where pready is sampled high.
    assign wr_ctrl = psel & penable & pready & pwrite & hit_ctrl;
    assign wr_host = psel & penable & pready & pwrite & hit_host;

    always_comb begin
        next_pready = psel & penable & ~pready;
        next_pslverr = next_pready & ~(hit_ctrl | hit_host);
        // Read data is zero outside a read answer, so no stale word lingers.
        next_prdata = ZERO_WORD;
        if (next_pready && !pwrite) begin
            if (hit_ctrl) begin
                next_prdata = ctrl & CTRL_RD_MASK;
            end else if (hit_host) begin
                next_prdata = {{(DATA_W - NUM_FILT){1'b0}}, host_mask};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= ZERO_WORD;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Control and host mask registers
    // ------------------------------------------------------------
    // Only presetn, the internal power-on reset, clears these registers.
    // A remote reset in the same cycle as a write still sets its flag.
    // The strap is looked at on every write, so a late strap still unlocks the hold bit.
    always_comb begin
        next_ctrl = ctrl;
        next_host_mask = host_mask;
        if (wr_ctrl) begin
            next_ctrl = (ctrl & ~CTRL_WR_MASK) | (pwdata & CTRL_WR_MASK);
            if (strap_s) begin
                next_ctrl[B_HOLD] = pwdata[B_HOLD];
            end
        end
        if (rrst_pulse) begin
            next_ctrl[B_REMOTE] = 1'b1;
        end
        if (wr_host) begin
            next_host_mask = pwdata[NUM_FILT-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            host_mask <= HOST_RESET;
        end else begin
            ctrl <= next_ctrl;
            host_mask <= next_host_mask;
        end
    end

    // ------------------------------------------------------------
    // Configuration fan-out
    // ------------------------------------------------------------
    // Every setting reaches the steering and PHY logic straight from its register bit.
    mpsc_cfg_if cfg_i ();

    assign cfg_i.rx_en = ctrl[B_RX_EN];
    assign cfg_i.mgmt_receive_everything = ctrl[B_MGMT_RECEIVE_EVERYTHING];
    assign cfg_i.mcast_pass = ctrl[B_MCAST];
    assign cfg_i.host_en = ctrl[B_HOST_EN];
    assign cfg_i.xsum_gate = ctrl[B_XSUM];
    assign cfg_i.type_lock = ctrl[B_TYPE_LOCK];
    assign cfg_i.type_sel = ctrl[B_TYPE_SEL];
    assign cfg_i.arp_dis = ctrl[B_ARP_DIS];
    assign cfg_i.hold = ctrl[B_HOLD];
    assign cfg_i.host_mask = host_mask;

    // The steering decision is registered, so its outputs follow a packet by one cycle.
    mpsc_steer u_steer (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_i),
        .pkt_valid(pkt_valid),
        .pkt_l2_pass(pkt_l2_pass),
        .pkt_multicast(pkt_multicast),
        .pkt_broadcast(pkt_broadcast),
        .pkt_xsum_ok(pkt_xsum_ok),
        .pkt_vlan_tagged(pkt_vlan_tagged),
        .pkt_arp_request(pkt_arp_request),
        .pkt_ip_filter_valid(pkt_ip_filter_valid),
        .pkt_ip_match(pkt_ip_match),
        .decision_filter_hit(decision_filter_hit),
        .wake_arp_in(wake_arp_in),
        .mgmt_forward(mgmt_forward),
        .host_copy(host_copy),
        .wake_arp_hit(wake_arp_hit)
    );

    // The PHY guard turns the hold and receive bits into reset and power decisions.
    mpsc_phy_guard u_phy (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_i),
        .pcie_reset(pcie_reset),
        .lowpower_req(lowpower_req),
        .phy_reset(phy_reset),
        .phy_power_keep(phy_power_keep),
        .phy_powerdown(phy_powerdown)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Properties are sampled on pclk and switched off while power-on reset is low.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    remote_flag_set_a: assert property (rrst_pulse |=> ctrl[B_REMOTE])
        else $error("remote reset flag not set");
    remote_flag_sticky_a: assert property (ctrl[B_REMOTE] |=> ctrl[B_REMOTE])
        else $error("remote reset flag cleared");
    hold_write_lock_a: assert property (!strap_s |=> $stable(ctrl[B_HOLD]))
        else $error("hold bit changed without strap");
    hold_only_write_a: assert property (!wr_ctrl |=> $stable(ctrl[B_HOLD]))
        else $error("hold bit changed without write");
    reserved_read_a: assert property (pready |-> (prdata & ~CTRL_RD_MASK) == ZERO_WORD
        || (hit_host && prdata[DATA_W-1:NUM_FILT] == '0))
        else $error("reserved bits read nonzero");
    rx_gate_a: assert property (!ctrl[B_RX_EN] |=> !mgmt_forward)
        else $error("forward without receive enable");
    host_gate_a: assert property (!ctrl[B_HOST_EN] |=> host_copy == HOST_RESET)
        else $error("host copy without global enable");
    xsum_gate_a: assert property (ctrl[B_XSUM] && pkt_valid && !pkt_xsum_ok
        |=> !mgmt_forward)
        else $error("bad checksum forwarded");
    mcast_bcast_a: assert property (!pkt_l2_pass && pkt_broadcast
        |=> !mgmt_forward)
        else $error("broadcast passed by multicast bit");
    phy_hold_a: assert property (ctrl[B_HOLD] |=> !phy_reset)
        else $error("phy reset while held");
    phy_power_a: assert property (ctrl[B_RX_EN] || ctrl[B_HOLD] |=> phy_power_keep)
        else $error("phy power not kept");
    apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
    unmapped_err_a: assert property (psel && penable && !pready && !hit_ctrl && !hit_host
        |=> pslverr && prdata == ZERO_WORD)
        else $error("unmapped access not refused");
    ctrl_read_a: assert property (psel && penable && !pready && !pwrite && hit_ctrl
        |=> prdata == $past(ctrl & CTRL_RD_MASK))
        else $error("control read data wrong");
    host_mask_wr_a: assert property (wr_host |=> host_mask == $past(pwdata[NUM_FILT-1:0]))
        else $error("host mask write lost");
    power_freeze_a: assert property (ctrl[B_HOLD]
        |=> phy_powerdown == $past(phy_powerdown))
        else $error("phy power state changed while held");
    host_copy_fwd_a: assert property (|host_copy |-> mgmt_forward)
        else $error("host copy without manageability forward");
    wake_indep_a: assert property (pkt_valid && pkt_arp_request && wake_arp_in
        |=> wake_arp_hit)
        else $error("wake-up ARP match lost");
    type_lock_a: assert property (ctrl[B_TYPE_LOCK] && pkt_valid
        && pkt_vlan_tagged != ctrl[B_TYPE_SEL] |=> !mgmt_forward)
        else $error("wrong tag type forwarded");
    arp_check_a: assert property (!ctrl[B_ARP_DIS] && pkt_valid && pkt_arp_request
        && !(pkt_ip_filter_valid && pkt_ip_match) |=> !mgmt_forward)
        else $error("unmatched ARP request forwarded");

    // ------------------------------------------------------------
    // Scenario coverage
    // ------------------------------------------------------------
    remote_seen_c: cover property (rrst_pulse ##1 ctrl[B_REMOTE]);
    host_copy_c: cover property (host_copy != HOST_RESET);
    mgmt_receive_everything_c: cover property (ctrl[B_MGMT_RECEIVE_EVERYTHING] ##1 mgmt_forward);
    phy_blocked_c: cover property (ctrl[B_HOLD] && pcie_reset);
    arp_checked_c: cover property (!ctrl[B_ARP_DIS] && pkt_valid && pkt_arp_request);
endmodule
`default_nettype wire
